// *** lpsc_top.sv ***
// Linear protection switch controller: requests, priority, APS, bridge,
// selector, timers, status and interrupt. Assumes a plain register port
// with read data one cycle after the strobe and asynchronous line inputs.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_map.svh"
module lpsc_top
  import lpsc_pkg::*;
#(
  parameter int CYC_PER_MS = `LPSC_CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [14:0] server_fail_in,
  input wire logic [14:0] trail_fail_in,
  input wire logic [14:0] trail_degrade_in,
  input wire logic [15:0] aps_rx,
  output logic [15:0] aps_tx,
  output logic [3:0] bridge_sel,
  output logic [3:0] selector_sel,
  output logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  function automatic logic [7:0] pick_high(input logic [7:0] a,
                                           input logic [7:0] b);
    return (b[7:4] > a[7:4]) ? b : a;
  endfunction

  function automatic logic [7:0] sig_request(input logic [14:0] f,
      input logic [14:0] d, input logic [3:0] nmax, input logic fhi,
      input logic dhi);
    logic [7:0] best;
    lpsc_req_t t;
    best = {`LPSC_RQ_NR, 4'h0};
    for (int i = 1; i < `LPSC_NSIG; i++) begin
      t = f[i] ? (fhi ? `LPSC_RQ_SF_H : `LPSC_RQ_SF_L) :
          d[i] ? (dhi ? `LPSC_RQ_SD_H : `LPSC_RQ_SD_L) : `LPSC_RQ_NR;
      if (i <= int'(nmax)) begin
        best = pick_high(best, {t, 4'(i)});
      end
    end
    if (f[0]) begin
      best = {`LPSC_RQ_SF_P, 4'h0};
    end
    return best;
  endfunction

  logic [`LPSC_CTRL_W-1:0] ctrl;
  logic [6:0] holdoff_setting;
  logic [9:0] restore_delay_setting;
  logic [3:0] istat, imask, resp;
  logic [14:0] sfs, tfs, tds;
  logic [15:0] aps_s, r_prev;
  logic [29:0] acc;
  logic [6:0] ho_cnt;
  logic [9:0] wtr_cnt;
  lpsc_req_t ext_req;
  lpsc_sig_t ext_sig, last_sig;
  lpsc_state_t state;
  logic was_fail;
  logic step_tick, sec_tick;

  lpsc_sync #(.W(61)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d({aps_rx, server_fail_in, trail_fail_in, trail_degrade_in}),
    .q({aps_s, sfs, tfs, tds})
  );

  wire ctrl_wr = reg_wr && reg_addr == `LPSC_ADDR_CTRL;
  wire tick_clr = ctrl_wr && reg_wdata[`LPSC_B_TCLR];

  lpsc_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(tick_clr),
    .ms_tick(),
    .step_tick(step_tick),
    .sec_tick(sec_tick)
  );

  // Configuration decode.
  wire architecture_select = ctrl[`LPSC_B_ARCH];
  wire direction_select = ctrl[`LPSC_B_DIR];
  wire revert_select = ctrl[`LPSC_B_REVERT];
  wire aps_enable = ctrl[`LPSC_B_APS];
  wire extra_traffic_enable = ctrl[`LPSC_B_EXTRA];
  wire [1:0] protection_kind = ctrl[`LPSC_F_KIND];
  wire inherent = protection_kind == `LPSC_KIND_INHERENT;
  wire [3:0] nmax = architecture_select ? `LPSC_NMAX : 4'h1;
  wire lim_bad = architecture_select && (!revert_select || !aps_enable);
  wire xtra_bad = extra_traffic_enable &&
                  !(architecture_select && direction_select);
  wire bidir_bad = !architecture_select && direction_select && !aps_enable;
  wire cfg_bad = lim_bad || xtra_bad || bidir_bad; // RULE1 RULE2
  wire [3:0] idle_sig = extra_traffic_enable ? `LPSC_XTRA : 4'h0;

  // Condition sources and hold-off.
  wire [14:0] fail_vec = inherent ? sfs : tfs; // RULE14
  wire [14:0] deg_vec = inherent ? 15'h0 : tds; // RULE14
  wire [29:0] raw = {deg_vec, fail_vec};
  wire new_cond = |(raw & ~acc);
  wire ho_done = new_cond && ho_cnt >= holdoff_setting; // RULE13

  // Signal, external, state, local and global requests.
  wire [7:0] sr = sig_request(acc[14:0], acc[29:15], nmax,
                              ctrl[`LPSC_B_FPRIO], ctrl[`LPSC_B_DPRIO]);
  wire work_fail = sr[7:4] >= `LPSC_RQ_SD_L &&
                   sr[7:4] <= `LPSC_RQ_SF_H;
  wire [7:0] st_req = state == ST_RESTORE_DELAY_WAIT ?
                      {`LPSC_RQ_WTR, last_sig} :
                      state == ST_NO_REVERT ? {`LPSC_RQ_DNR, 4'h1} : 8'h0;
  wire [7:0] loc_all = pick_high(pick_high(sr, {ext_req, ext_sig}),
                                 st_req); // RULE5
  wire [7:0] loc = cfg_bad ? 8'h0 : loc_all;
  wire lpsc_req_t r_type = aps_s[15:12]; // RULE6
  wire lpsc_sig_t r_sig = aps_s[11:8];
  wire lpsc_sig_t r_bridge = aps_s[7:4];
  wire take_remote = aps_enable && direction_select && !cfg_bad &&
                     r_type > loc[7:4] && r_type != `LPSC_RQ_RR; // RULE7
  wire lpsc_req_t g_type = take_remote ? `LPSC_RQ_RR : loc[7:4];
  wire lpsc_sig_t g_sig = take_remote ? r_sig : loc[3:0];
  wire lpsc_req_t eff_type = take_remote ? r_type : loc[7:4];
  wire no_move = eff_type == `LPSC_RQ_LO || eff_type == `LPSC_RQ_SF_P ||
                 eff_type == `LPSC_RQ_EXER || eff_type == `LPSC_RQ_NR;
  wire [3:0] sw_sig = (no_move || g_sig == 4'h0) ? 4'h0 : g_sig;
  // Lockout keeps extra traffic off the protection path as well.
  wire [3:0] free_sig = eff_type == `LPSC_RQ_LO ? 4'h0 : idle_sig;
  wire [3:0] next_bridge = !architecture_select ? 4'h1 :
                           (sw_sig != 4'h0 ? sw_sig : free_sig); // RULE8
  wire [3:0] next_sel = !architecture_select ? sw_sig :
                        (aps_enable && direction_select &&
                         r_bridge != next_bridge) ? free_sig :
                        next_bridge; // RULE9

  // Operator commands and their answers.
  wire cmd_wr = reg_wr && reg_addr == `LPSC_ADDR_CMD;
  wire [2:0] op = reg_wdata[2:0];
  wire [3:0] cmd_sig = reg_wdata[7:4];
  wire lpsc_req_t cmd_code = op == `LPSC_OP_LO ? `LPSC_RQ_LO :
                             op == `LPSC_OP_FS ? `LPSC_RQ_FS :
                             op == `LPSC_OP_MS ? `LPSC_RQ_MS :
                             op == `LPSC_OP_EXER ? `LPSC_RQ_EXER :
                             `LPSC_RQ_NR;
  wire op_sw = op == `LPSC_OP_FS || op == `LPSC_OP_MS;
  wire to_work = !architecture_select && !revert_select && op_sw;
  wire xtra_ok = op == `LPSC_OP_FS && cmd_sig == `LPSC_XTRA &&
                 extra_traffic_enable;
  wire arg_bad = op > `LPSC_OP_EXER || cfg_bad ||
                 (op != `LPSC_OP_CLR && op != `LPSC_OP_LO &&
                  ((cmd_sig == 4'h0 && !to_work) ||
                   (cmd_sig > nmax && !xtra_ok)));
  wire prio_bad = op != `LPSC_OP_CLR && ext_req != `LPSC_RQ_NR &&
                  ext_req >= cmd_code; // RULE16
  wire defect_bad = (op == `LPSC_OP_FS && aps_enable && acc[0]) ||
                    (op == `LPSC_OP_MS && |acc) ||
                    (op == `LPSC_OP_EXER && selector_sel != idle_sig);
  wire deny = arg_bad || prio_bad || defect_bad;
  wire [1:0] cause = arg_bad ? `LPSC_CAUSE_ARG :
                     prio_bad ? `LPSC_CAUSE_PRIO : `LPSC_CAUSE_DEFECT;
  wire resp_ev = cmd_wr && op != 3'h0; // RULE17

  // Restore delay and revert handling.
  wire leave_wait = work_fail || ext_req != `LPSC_RQ_NR;
  wire wtr_done = state == ST_RESTORE_DELAY_WAIT && !leave_wait &&
                  wtr_cnt >= restore_delay_setting; // RULE12
  wire cleared = was_fail && !work_fail && ext_req == `LPSC_RQ_NR;

  // Events and register reads.
  wire lchg = {g_type, g_sig} != aps_tx[15:8];
  wire rchg = aps_enable && aps_s != r_prev;
  wire [3:0] events = {wtr_done, rchg, lchg, resp_ev};
  wire [3:0] w1c = (reg_wr && reg_addr == `LPSC_ADDR_ISTAT) ?
                   reg_wdata[3:0] : 4'h0;
  wire [31:0] lstat = {1'b0, cfg_bad, 2'(state), selector_sel, bridge_sel,
                       g_type, g_sig, loc[7:4], loc[3:0],
                       ext_req}; // RULE11
  wire [31:0] rstat = aps_enable ? {16'h0, aps_s} : 32'h0; // RULE11
  wire [31:0] rd_mux =
    reg_addr == `LPSC_ADDR_CTRL ? {23'h0, ctrl} :
    reg_addr == `LPSC_ADDR_HOLDOFF ? {25'h0, holdoff_setting} :
    reg_addr == `LPSC_ADDR_RESTORE ? {22'h0, restore_delay_setting} :
    reg_addr == `LPSC_ADDR_CMD ? {24'h0, ext_sig, ext_req} :
    reg_addr == `LPSC_ADDR_RESP ? {28'h0, resp} :
    reg_addr == `LPSC_ADDR_LSTAT ? lstat :
    reg_addr == `LPSC_ADDR_RSTAT ? rstat :
    reg_addr == `LPSC_ADDR_ISTAT ? {28'h0, istat} :
    reg_addr == `LPSC_ADDR_IMASK ? {28'h0, imask} : 32'h0;

  assign irq = |(istat & imask);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `LPSC_CTRL_RST;
      holdoff_setting <= '0;
      restore_delay_setting <= '0;
      imask <= '0;
      istat <= '0;
      reg_rdata <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl <= reg_wdata[`LPSC_CTRL_W-1:0];
      end
      if (reg_wr && reg_addr == `LPSC_ADDR_HOLDOFF) begin
        holdoff_setting <= reg_wdata[6:0] > `LPSC_HOLDOFF_MAX ?
                           `LPSC_HOLDOFF_MAX : reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == `LPSC_ADDR_RESTORE) begin
        restore_delay_setting <= reg_wdata[9:0] > `LPSC_RESTORE_MAX ?
                                 `LPSC_RESTORE_MAX : reg_wdata[9:0];
      end
      if (reg_wr && reg_addr == `LPSC_ADDR_IMASK) begin
        imask <= reg_wdata[3:0];
      end
      // A new event wins over a clear in the same cycle.
      istat <= (istat & ~w1c) | events;
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
      ho_cnt <= '0;
    end else begin
      acc <= ho_done ? raw : (acc & raw); // RULE13
      ho_cnt <= !new_cond ? 7'h0 :
                (step_tick ? ho_cnt + 7'h1 : ho_cnt); // RULE13
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_req <= `LPSC_RQ_NR;
      ext_sig <= '0;
      resp <= '0;
    end else if (resp_ev) begin
      resp <= {cause & {2{deny}}, deny, 1'b1}; // RULE17
      if (op == `LPSC_OP_CLR) begin
        ext_req <= `LPSC_RQ_NR;
        ext_sig <= '0;
      end else if (!deny) begin
        ext_req <= cmd_code; // RULE4 RULE16
        ext_sig <= cmd_sig;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_NO_REQ;
      wtr_cnt <= '0;
      was_fail <= 1'b0;
      last_sig <= '0;
    end else begin
      was_fail <= work_fail;
      if (work_fail) begin
        last_sig <= sr[3:0]; // RULE3
      end
      case (state)
        ST_NO_REQ: begin
          wtr_cnt <= '0;
          if (cleared) begin
            state <= revert_select ? ST_RESTORE_DELAY_WAIT : ST_NO_REVERT;
          end
        end
        ST_RESTORE_DELAY_WAIT: begin
          if (leave_wait || wtr_done) begin
            state <= ST_NO_REQ; // RULE18
          end else if (sec_tick) begin
            wtr_cnt <= wtr_cnt + 10'h1; // RULE12
          end
        end
        ST_NO_REVERT: begin
          if (leave_wait) begin
            state <= ST_NO_REQ;
          end
        end
        default: state <= ST_NO_REQ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aps_tx <= '0;
      bridge_sel <= '0;
      selector_sel <= '0;
      r_prev <= '0;
    end else begin
      aps_tx <= {g_type, g_sig, next_bridge, architecture_select,
                 direction_select, 2'b00}; // RULE10
      bridge_sel <= cfg_bad ? 4'h0 : next_bridge; // RULE8
      selector_sel <= cfg_bad ? 4'h0 : next_sel; // RULE9
      r_prev <= aps_s;
    end
  end

  a_cfg_bad_quiet: // RULE1
    assert property (cfg_bad |=> bridge_sel == 4'h0 &&
                     aps_tx[15:12] == `LPSC_RQ_NR)
    else $error("invalid setup still switches");
  a_bidir_needs_aps: // RULE2
    assert property ((!architecture_select && direction_select &&
                      !aps_enable) |-> cfg_bad)
    else $error("bidirectional 1+1 accepted without APS");
  a_inherent_no_sd: // RULE14
    assert property (inherent |-> deg_vec == 15'h0 && fail_vec == sfs)
    else $error("inherent protection uses trail inputs");
  a_cmd_answer: // RULE17
    assert property (resp_ev |=> resp[0] && resp[1] == $past(deny))
    else $error("command not answered");
  a_tx_follows: // RULE10
    assert property (!cfg_bad ##1 1 |-> aps_tx[15:12] == $past(g_type) &&
                     aps_tx[11:8] == $past(g_sig))
    else $error("sent word does not carry global request");
  a_remote_hidden: // RULE11
    assert property ((reg_rd && reg_addr == `LPSC_ADDR_RSTAT &&
                      !aps_enable) |=> reg_rdata == 32'h0)
    else $error("remote status shown without APS");
  a_local_only: // RULE7
    assert property (!aps_enable |-> g_type == loc[7:4])
    else $error("remote request used without APS");
  a_wait_preempt: // RULE18
    assert property ((state == ST_RESTORE_DELAY_WAIT && work_fail)
                     |=> state == ST_NO_REQ)
    else $error("condition did not pre-empt restore wait");
  a_holdoff_hold: // RULE13
    assert property ((new_cond && ho_cnt < holdoff_setting) |=>
                     (acc & ~$past(acc)) == 30'h0)
    else $error("condition taken before hold-off ended");
endmodule
`default_nettype wire

// *** lpsc_map.svh ***
// Register offsets, field positions, request codes and timing counts of
// the linear protection switch controller; plain defines, no logic.
// Summary of operation
// [RULE1] Listed setups only: 1:n up to 14, revertive, APS; extra 1:n bidir.
// [RULE2] Bidirectional one-plus-one path protection needs APS enabled.
// [RULE3] Fail and degrade per path become a signal request with number.
// [RULE4] Operator commands become an external request and signal number.
// [RULE5] Local stage picks the highest of signal, external and state requests.
// [RULE6] Received APS word decodes to type, signal, bridged, architecture; the architecture bits aps_s[3:2] are never decoded.
// [RULE7] Global stage weighs remote against local only with APS enabled.
// [RULE8] Bridge control picks the signal copied onto protection.
// [RULE9] Selector control picks the signal taken from protection.
// [RULE10] Sent APS word holds global type, signal, bridge, architecture.
// [RULE11] Local status always readable; remote status only with APS on.
// [RULE12] Restore delay of zero to twelve minutes before reverting.
// [RULE13] Hold-off of zero to ten seconds in 100 ms steps on conditions.
// [RULE14] Inherent: fail from server fail; others: trail fail, degrade.
// [RULE15] Operator offers lockout, forced, manual, exercise and clear only.
// [RULE16] Single request; ranked clear, lockout, forced, manual, exercise.
// [RULE17] Every command gets an automatic confirm or denial with cause.
// [RULE18] Fail or degrade pre-empts restore wait; expiry reverts traffic.
// [RULE19] Timers run from a free millisecond tick with synchronous clear.
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

`define LPSC_ADDR_CTRL 8'h00
`define LPSC_ADDR_HOLDOFF 8'h04
`define LPSC_ADDR_RESTORE 8'h08
`define LPSC_ADDR_CMD 8'h0c
`define LPSC_ADDR_RESP 8'h10
`define LPSC_ADDR_LSTAT 8'h14
`define LPSC_ADDR_RSTAT 8'h18
`define LPSC_ADDR_ISTAT 8'h1c
`define LPSC_ADDR_IMASK 8'h20

// Control register fields.
`define LPSC_CTRL_W 9
`define LPSC_CTRL_RST 9'h000
`define LPSC_B_ARCH 0
`define LPSC_B_DIR 1
`define LPSC_B_REVERT 2
`define LPSC_B_APS 3
`define LPSC_B_EXTRA 4
`define LPSC_F_KIND 6:5
`define LPSC_B_FPRIO 7
`define LPSC_B_DPRIO 8
`define LPSC_B_TCLR 9
`define LPSC_KIND_INHERENT 2'h1

// Request codes, larger value is higher priority.
`define LPSC_RQ_NR 4'h0
`define LPSC_RQ_DNR 4'h1
`define LPSC_RQ_RR 4'h2
`define LPSC_RQ_EXER 4'h4
`define LPSC_RQ_WTR 4'h5
`define LPSC_RQ_MS 4'h7
`define LPSC_RQ_SD_L 4'h8
`define LPSC_RQ_SD_H 4'h9
`define LPSC_RQ_SF_L 4'ha
`define LPSC_RQ_SF_H 4'hb
`define LPSC_RQ_FS 4'hd
`define LPSC_RQ_SF_P 4'he
`define LPSC_RQ_LO 4'hf

// Operator command codes and answer causes.
`define LPSC_OP_CLR 3'h1
`define LPSC_OP_LO 3'h2
`define LPSC_OP_FS 3'h3
`define LPSC_OP_MS 3'h4
`define LPSC_OP_EXER 3'h5
`define LPSC_CAUSE_PRIO 2'h1
`define LPSC_CAUSE_DEFECT 2'h2
`define LPSC_CAUSE_ARG 2'h3

`define LPSC_NMAX 4'he
`define LPSC_XTRA 4'hf
`define LPSC_NSIG 15

// Timing.
`define LPSC_CLK_NS 10
`define LPSC_MS_NS 1000000
`define LPSC_CYC_PER_MS (`LPSC_MS_NS / `LPSC_CLK_NS)
`define LPSC_MS_PER_STEP 7'h64
`define LPSC_STEP_PER_SEC 4'ha
`define LPSC_HOLDOFF_MAX 7'h64
`define LPSC_RESTORE_MAX 10'h2d0

`endif

// *** lpsc_pkg.sv ***
// Types shared by the protection switch controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package lpsc_pkg;
  typedef logic [3:0] lpsc_req_t;
  typedef logic [3:0] lpsc_sig_t;
  typedef enum logic [1:0] {
    ST_NO_REQ,
    ST_RESTORE_DELAY_WAIT,
    ST_NO_REVERT
  } lpsc_state_t;
endpackage

// *** lpsc_sync.sv ***
// Three-stage input synchroniser with agreement of the last two stages.
// Assumes inputs that come from outside the ref_clk domain.
`timescale 1ns/100ps
`default_nettype none
module lpsc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1, s2, s3;
  wire [W-1:0] differ = s2 ^ s3;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s3 & ~differ) | (q & differ);
    end
  end
endmodule
`default_nettype wire

// *** lpsc_tick.sv ***
// Free-running millisecond, 100 ms and one-second enable pulses.
// Assumes ref_clk at 100 MHz and a synchronous clear from software.
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_map.svh"
module lpsc_tick #(
  parameter int CYC_PER_MS = `LPSC_CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clr,
  output logic ms_tick,
  output logic step_tick,
  output logic sec_tick
);
  logic [16:0] cyc;
  logic [6:0] ms_cnt;
  logic [3:0] step_cnt;
  wire cyc_end = cyc == 17'(CYC_PER_MS - 1);
  wire ms_end = ms_cnt == `LPSC_MS_PER_STEP - 7'h01;
  wire step_end = step_cnt == `LPSC_STEP_PER_SEC - 4'h1;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc <= '0;
      ms_cnt <= '0;
      step_cnt <= '0;
      ms_tick <= 1'b0;
      step_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else if (clr) begin // RULE19
      cyc <= '0;
      ms_cnt <= '0;
      step_cnt <= '0;
      ms_tick <= 1'b0;
      step_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      cyc <= cyc_end ? 17'h0 : cyc + 17'h1; // RULE19
      ms_tick <= cyc_end;
      step_tick <= cyc_end && ms_end;
      sec_tick <= cyc_end && ms_end && step_end;
      if (cyc_end) begin
        ms_cnt <= ms_end ? 7'h0 : ms_cnt + 7'h1;
        if (ms_end) begin
          step_cnt <= step_end ? 4'h0 : step_cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** lpsc_far_end.sv ***
// Far-end protection process model that answers the sent APS word.
// Assumes the controller's clock and reset; slow delays it 8 cycles.
`timescale 1ns/100ps
`default_nettype none
module lpsc_far_end (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [15:0] aps_tx,
  output logic [15:0] aps_rx
);
  logic [127:0] pipe;
  logic [15:0] src;
  logic [15:0] next_word;
  assign src = slow ? pipe[127:112] : aps_tx;
  // A request above reverse request is answered by reverse request for the
  // same signal, bridged as asked; anything else is answered by no request.
  assign next_word = (src[15:12] > 4'h2) ?
    {4'h2, src[11:8], src[11:8], src[3:2], 2'h0} :
    {8'h00, src[7:4], src[3:2], 2'h0};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pipe <= '0;
      aps_rx <= '0;
    end else begin
      pipe <= {pipe[111:0], aps_tx};
      aps_rx <= next_word;
    end
  end
endmodule
`default_nettype wire

// *** lpsc_top_tb.sv ***
// Self-checking bench for the protection switch controller.
// Assumes lpsc_top, lpsc_far_end and the register map header.
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_map.svh"
module lpsc_top_tb;
  logic ref_clk, rstn, reg_wr, reg_rd, irq, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [14:0] sfail, tfail, tdeg;
  logic [15:0] aps_rx, aps_tx;
  logic [3:0] bridge_sel, selector_sel;
  int fails, comparisons;
  logic [7:0] cmd [10] = '{8'h24, 8'h02, 8'h02, 8'h06, 8'h01,
    8'hf3, 8'h01, 8'hf4, 8'h35, 8'h01};
  logic [3:0] rsp [10] = '{4'h7, 4'h1, 4'h7, 4'hf, 4'h1,
    4'h1, 4'h1, 4'hf, 4'h1, 4'h1};
  logic [3:0] typ [10] = '{4'hd, 4'hf, 4'hf, 4'hf, 4'h0,
    4'hd, 4'h0, 4'h0, 4'h4, 4'h0};
  logic [3:0] brg [10] = '{4'h1, 4'h0, 4'h0, 4'h0, 4'hf,
    4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
  logic [8:0] cfg [5] = '{9'h000, 9'h00a, 9'h002, 9'h010, 9'h001};
  // Expected bridge in the upper four bits, bad setup flag in bit 0.
  logic [4:0] cfgx [5] = '{5'h02, 5'h02, 5'h01, 5'h01, 5'h01};

  lpsc_top #(.CYC_PER_MS(10)) i_lpsc_top (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .server_fail_in(sfail),
    .trail_fail_in(tfail), .trail_degrade_in(tdeg), .aps_rx(aps_rx),
    .aps_tx(aps_tx), .bridge_sel(bridge_sel),
    .selector_sel(selector_sel), .irq(irq));
  lpsc_far_end i_lpsc_far_end (.ref_clk(ref_clk), .rstn(rstn),
    .slow(slow), .aps_tx(aps_tx), .aps_rx(aps_rx));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk) v = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    sfail = 15'h0;
    tfail = 15'h0;
    tdeg = 15'h0;
    slow = 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    settle(1);
    chk(bridge_sel, 4'h1);
    rchk(`LPSC_ADDR_CTRL, 32'h0);
    rchk(`LPSC_ADDR_IMASK, 32'h0);
    rchk(`LPSC_ADDR_RSTAT, 32'h0);
    wr(8'h24, 32'hff);
    rchk(8'h24, 32'h0);
    wr(`LPSC_ADDR_HOLDOFF, 32'h7f);
    rchk(`LPSC_ADDR_HOLDOFF, 32'h64);
    wr(`LPSC_ADDR_RESTORE, 32'h3ff);
    rchk(`LPSC_ADDR_RESTORE, 32'h2d0);
    wr(`LPSC_ADDR_HOLDOFF, 32'h0);
    wr(`LPSC_ADDR_RESTORE, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(`LPSC_ADDR_CTRL, {23'h0, cfg[i]});
      settle(4);
      chk(bridge_sel, cfgx[i][4:1]);
      rd(`LPSC_ADDR_LSTAT);
      chk(v[30], cfgx[i][0]);
    end
    wr(`LPSC_ADDR_CMD, 32'h13);
    rchk(`LPSC_ADDR_RESP, 32'hf);
    wr(`LPSC_ADDR_CTRL, 32'h21f);
    rchk(`LPSC_ADDR_CTRL, 32'h1f);
    wr(`LPSC_ADDR_IMASK, 32'h1);
    wr(`LPSC_ADDR_ISTAT, 32'hf);
    slow <= 1'b1;
    settle(40);
    chk(irq, 1'b0);
    wr(`LPSC_ADDR_CMD, 32'h13);
    rchk(`LPSC_ADDR_RESP, 32'h1);
    chk(irq, 1'b1);
    rchk(`LPSC_ADDR_CMD, 32'h1d);
    settle(40);
    chk(aps_tx, 16'hd11c);
    chk(bridge_sel, 4'h1);
    chk(selector_sel, 4'h1);
    rchk(`LPSC_ADDR_RSTAT, 32'h211c);
    wr(`LPSC_ADDR_ISTAT, 32'h1);
    settle(1);
    chk(irq, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wr(`LPSC_ADDR_CMD, {24'h0, cmd[i]});
      rchk(`LPSC_ADDR_RESP, {28'h0, rsp[i]});
      settle(40);
      chk(aps_tx[15:12], typ[i]);
      chk(bridge_sel, brg[i]);
    end
    slow <= 1'b0;
    wr(`LPSC_ADDR_HOLDOFF, 32'h2);
    tfail <= 15'h4;
    settle(400);
    chk(aps_tx[15:12], 4'h0);
    settle(1700);
    chk(aps_tx[15:8], 8'ha2);
    chk(bridge_sel, 4'h2);
    wr(`LPSC_ADDR_HOLDOFF, 32'h0);
    tfail <= 15'h0;
    settle(20);
    rd(`LPSC_ADDR_LSTAT);
    chk(v[29:28], 2'h1);
    chk(aps_tx[15:12], 4'h5);
    @(posedge ref_clk);
    tdeg <= 15'h8;
    settle(20);
    chk(aps_tx[15:8], 8'h83);
    @(posedge ref_clk);
    tdeg <= 15'h0;
    settle(20100);
    rd(`LPSC_ADDR_ISTAT);
    chk(v[3], 1'b1);
    chk(aps_tx[15:12], 4'h0);
    wr(`LPSC_ADDR_RESTORE, 32'h0);
    wr(`LPSC_ADDR_CTRL, 32'h19f);
    tdeg <= 15'h8;
    settle(20);
    chk(aps_tx[15:8], 8'h93);
    @(posedge ref_clk);
    tdeg <= 15'h0;
    settle(20);
    wr(`LPSC_ADDR_CTRL, 32'h20);
    tfail <= 15'h2;
    settle(20);
    chk(selector_sel, 4'h0);
    @(posedge ref_clk);
    sfail <= 15'h2;
    settle(20);
    chk(selector_sel, 4'h1);
    @(posedge ref_clk);
    sfail <= 15'h0;
    tfail <= 15'h0;
    settle(20);
    rd(`LPSC_ADDR_LSTAT);
    chk(v[29:28], 2'h2);
    chk(selector_sel, 4'h1);
    rchk(`LPSC_ADDR_RSTAT, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
